// ==== rtl/brp_pkg.sv ====
// Shared constants and carriers for the boot retest protection loader.
// Assumes a byte-wide non-volatile memory with one cycle read latency.
package brp_pkg;

    // ****************************************************************
    // Memory layout
    // ****************************************************************
    localparam int          NVM_AW        = 13;
    localparam int          VENDOR_BYTES  = 64;
    localparam logic [12:0] PROT_BYTE_ADR = 13'h0000; // Start of factory

    // ****************************************************************
    // Protection byte field positions
    // ****************************************************************
    localparam int PB_NVM_LOCK  = 7;
    localparam int PB_EE_LOCK   = 6;
    localparam int PB_RAM_CLEAR = 5;
    localparam int PB_EARLY_XO  = 4;
    localparam int PB_AUTO_RUN  = 1;

    // ****************************************************************
    // Live protection register fields and program level codes
    // ****************************************************************
    localparam int         LP_NVM_LOCK = 7;
    localparam int         LP_DBG_OFF  = 6;
    localparam int         LP_EE_LOCK  = 4;
    localparam int         LP_NVM_WP   = 3;
    localparam logic [7:0] LP_RESET    = 8'h20; // Reserved bit 5 reads 1
    localparam logic [7:0] LP_WR_MASK  = 8'hDF;
    localparam logic [2:0] LVL_FACTORY = 3'h1;
    localparam logic [2:0] LVL_USER    = 3'h3;
    localparam logic [2:0] LVL_RUN     = 3'h7;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] REG_LIVE   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;

    // ****************************************************************
    // CRC32 constants
    // ****************************************************************
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

    // Debug port operations
    typedef enum logic [1:0] {
        DOP_READ      = 2'b00,
        DOP_WRITE     = 2'b01,
        DOP_CRC_FACT  = 2'b10,
        DOP_CRC_USER  = 2'b11
    } brp_dop_e;

    // Debug port request
    typedef struct packed {
        brp_dop_e          op;
        logic [NVM_AW-1:0] addr;
        logic [7:0]        wdata;
    } brp_dbg_s;

    // Non-volatile memory access
    typedef struct packed {
        logic              rd;
        logic              we;
        logic [NVM_AW-1:0] addr;
        logic [7:0]        wdata;
    } brp_nvm_s;

endpackage

// ==== rtl/brp_crc32.sv ====
// Byte-serial CRC32 engine used by the loader for region checksums.
// Assumes bytes arrive one per cycle on feed; init restarts the sum.
`timescale 1ns/1ns
`default_nettype none

module brp_crc32 (
    // System
    input  wire logic        clk,
    input  wire logic        reset,
    // Byte stream
    input  wire logic        init,
    input  wire logic        feed,
    input  wire logic [7:0]  data,
    // Result
    output logic      [31:0] crc
);

    // ****************************************************************
    // Reflected byte update
    // ****************************************************************
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0]  d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ brp_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    logic [31:0] sum_reg;
    logic [31:0] sum_next;

    // Init wins over feed so a new run never mixes with the last one
    assign sum_next = init ? brp_pkg::CRC_INIT :
                      feed ? crc_byte(sum_reg, data) : sum_reg;

    // Running sum
    always_ff @(posedge clk) begin
        if (reset) begin
            sum_reg <= brp_pkg::CRC_INIT;
        end else begin
            sum_reg <= sum_next;
        end
    end

    assign crc = ~sum_reg; // Final inversion

endmodule // brp_crc32

`default_nettype wire

// ==== rtl/brp_loader.sv ====
// Boot sequencer that applies the retest protection byte, plus the
// live protection register and the gate for debug port NVM requests.
// Assumes NVM read data one cycle after rd, and an external loader
// that copies NVM images to RAM while load_go is high.
`timescale 1ns/1ns
`default_nettype none

module brp_loader #(
    parameter int NVM_BYTES     = 8192,
    parameter int FACTORY_BYTES = 1024,
    parameter int RAM_WORDS     = 4096,
    parameter int RAM_AW        = 12
) (
    // System
    input  wire logic              clk,
    input  wire logic              reset,
    // Boot control
    input  wire logic              boot_start,
    input  wire logic              retest_seen,
    input  wire logic [2:0]        fuse_level,
    input  wire logic              load_done,
    output logic                   load_go,
    output logic                   load_user,
    output logic                   early_xo_en,
    output logic                   user_run,
    output logic                   boot_done,
    output logic                   debug_open,
    // Memory locks
    output logic                   eeprom_lock,
    output logic                   nvm_lock,
    // RAM clear
    output logic                   ram_clr_we,
    output logic [RAM_AW-1:0]      ram_clr_addr,
    // NVM port
    output brp_pkg::brp_nvm_s      nvm,
    input  wire logic [7:0]        nvm_rdata,
    // Debug port requests
    input  wire logic              dbg_req,
    input  wire brp_pkg::brp_dbg_s dbg,
    output logic                   dbg_ack,
    output logic                   dbg_refused,
    output logic [7:0]             dbg_rdata,
    output logic [31:0]            dbg_crc,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata
);

    localparam int AW = brp_pkg::NVM_AW;

    // Geometry the counters cannot serve
    initial begin
        if (NVM_BYTES > (1 << AW) || FACTORY_BYTES < 1 ||
            FACTORY_BYTES + brp_pkg::VENDOR_BYTES >= NVM_BYTES ||
            RAM_WORDS > (1 << RAM_AW) || RAM_WORDS < 1) begin
            $error("brp_loader: unsupported memory geometry");
        end
    end

    localparam logic [AW-1:0] FACT_LAST   = AW'(FACTORY_BYTES - 1);
    localparam logic [AW-1:0] USER_FIRST  = AW'(FACTORY_BYTES);
    localparam logic [AW-1:0] VENDOR_BASE =
        AW'(NVM_BYTES - brp_pkg::VENDOR_BYTES);
    localparam logic [AW-1:0] USER_LAST   = VENDOR_BASE - AW'(1);
    localparam logic [RAM_AW-1:0] RAM_LAST = RAM_AW'(RAM_WORDS - 1);

    // ****************************************************************
    // Boot state machine
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_FETCH  = 4'b0001,
        ST_CATCH  = 4'b0010,
        ST_LOAD   = 4'b0011,
        ST_EELOCK = 4'b0100,
        ST_CLEAR  = 4'b0101,
        ST_NVLOCK = 4'b0110,
        ST_READY  = 4'b0111,
        ST_DREAD  = 4'b1000,
        ST_CRC    = 4'b1001,
        ST_CRCEND = 4'b1010
    } brp_state_e;

    brp_state_e        state_reg;
    brp_state_e        state_next;
    logic [7:0]        prot_reg;     // Internal copy, reaches a port only ORed into nvm.wdata
    logic              retest_reg;
    logic [7:0]        live_reg;
    logic [7:0]        live_next;
    logic              xo_reg;
    logic              run_reg;
    logic              done_reg;
    logic              open_reg;
    logic [RAM_AW-1:0] clr_reg;
    logic [AW-1:0]     crc_adr_reg;
    logic [AW-1:0]     crc_end_reg;
    logic              crc_feed_reg;
    logic              ack_reg;
    logic              ref_reg;
    logic [7:0]        rdata_reg;
    logic [7:0]        reg_rdata_reg;
    logic [31:0]       crc_val;

    // Level decode from the live register and from the fuse_level input
    wire [2:0] level    = live_reg[2:0];
    wire       at_run   = (level == brp_pkg::LVL_RUN);
    wire       at_user  = (level == brp_pkg::LVL_USER);
    wire       fuse_run = (fuse_level == brp_pkg::LVL_RUN);
    wire       retest   = retest_seen & fuse_run;

    // Flags only matter in a retest of a run part
    wire f_nvm = retest_reg & prot_reg[brp_pkg::PB_NVM_LOCK];
    wire f_ee  = retest_reg & prot_reg[brp_pkg::PB_EE_LOCK];
    wire f_ram = retest_reg & prot_reg[brp_pkg::PB_RAM_CLEAR];
    // Bits 3, 2 and 0 are never decoded.

    // Auto run: user level only, else plain run parts start.
    wire go_user = at_user ? prot_reg[brp_pkg::PB_AUTO_RUN]
                           : (at_run & ~retest_reg);

    // ****************************************************************
    // Debug request gate
    // ****************************************************************
    wire lk_nvm   = live_reg[brp_pkg::LP_NVM_LOCK];
    wire wp_act   = live_reg[brp_pkg::LP_NVM_WP] & at_run;
    wire in_vend  = (dbg.addr >= VENDOR_BASE);
    wire hit_prot = (dbg.addr == brp_pkg::PROT_BYTE_ADR);
    wire port_ok  = open_reg & ~live_reg[brp_pkg::LP_DBG_OFF];
    wire take     = dbg_req & (state_reg == ST_READY);

    // Per operation permission under the current locks
    logic op_ok;
    always_comb begin
        unique case (dbg.op)
            brp_pkg::DOP_READ:     op_ok = ~lk_nvm | in_vend;
            brp_pkg::DOP_WRITE:    op_ok = ~lk_nvm & ~wp_act &
                                           ~(hit_prot & at_run);
            brp_pkg::DOP_CRC_FACT: op_ok = 1'b1;
            brp_pkg::DOP_CRC_USER: op_ok = 1'b1;
        endcase
    end

    wire accept = take & port_ok & op_ok;
    wire refuse = take & ~(port_ok & op_ok);
    wire is_crc = dbg.op[1];

    // Protection byte write only ORs new ones in.
    wire [7:0] wr_byte = hit_prot ? (prot_reg | dbg.wdata) : dbg.wdata;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (boot_start) state_next = ST_FETCH;
            ST_FETCH:  state_next = ST_CATCH;
            ST_CATCH:  state_next = ST_LOAD;
            ST_LOAD: begin
                if (load_done) begin
                    state_next = retest_reg ? ST_EELOCK : ST_READY;
                end
            end
            ST_EELOCK: state_next = f_ram ? ST_CLEAR : ST_NVLOCK;
            ST_CLEAR: begin
                if (clr_reg == RAM_LAST) state_next = ST_NVLOCK;
            end
            ST_NVLOCK: state_next = ST_READY;
            ST_READY: begin
                if (accept && is_crc) begin
                    state_next = ST_CRC;
                end else if (accept && dbg.op == brp_pkg::DOP_READ) begin
                    state_next = ST_DREAD;
                end
            end
            ST_DREAD:  state_next = ST_READY;
            ST_CRC: begin
                if (crc_adr_reg == crc_end_reg) state_next = ST_CRCEND;
            end
            ST_CRCEND: state_next = ST_READY;
            default:   state_next = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Live protection register
    // ****************************************************************
    wire sw_set = reg_wr & (reg_addr == brp_pkg::REG_LIVE);
    wire [7:0] sw_bits  = sw_set ? (reg_wdata & brp_pkg::LP_WR_MASK)
                                 : 8'h00;
    wire [7:0] lvl_bits = (state_reg == ST_CATCH) ? {5'h00, fuse_level}
                                                  : 8'h00;
    wire [7:0] ee_bits  = (state_reg == ST_EELOCK && f_ee) ?
                          8'h10 : 8'h00;
    wire [7:0] nv_bits  = (state_reg == ST_NVLOCK && f_nvm) ?
                          8'h80 : 8'h00;

    // Every source only ORs bits in, so no write can clear.
    assign live_next = live_reg | sw_bits | lvl_bits | ee_bits | nv_bits;

    // ****************************************************************
    // Boot registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= ST_IDLE;
            live_reg   <= brp_pkg::LP_RESET;
            prot_reg   <= 8'h00;
            retest_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            live_reg  <= live_next;
            if (state_reg == ST_CATCH) begin
                prot_reg   <= nvm_rdata;
                retest_reg <= retest;
            end else if (accept && dbg.op == brp_pkg::DOP_WRITE &&
                         hit_prot) begin
                prot_reg <= wr_byte;
            end
        end
    end

    // Oscillator, run and port state
    always_ff @(posedge clk) begin
        if (reset) begin
            xo_reg   <= 1'b0;
            run_reg  <= 1'b0;
            done_reg <= 1'b0;
            open_reg <= 1'b0;
        end else begin
            if (state_reg == ST_CATCH &&
                nvm_rdata[brp_pkg::PB_EARLY_XO]) begin
                xo_reg <= 1'b1;
            end
            if (state_reg == ST_LOAD && state_next == ST_READY) begin
                run_reg <= go_user;
            end
            if (state_next == ST_READY && !done_reg) begin
                done_reg <= 1'b1;
                open_reg <= retest_reg | ~at_run;
            end
        end
    end

    // RAM clear walk and CRC address walk
    always_ff @(posedge clk) begin
        if (reset) begin
            clr_reg      <= '0;
            crc_adr_reg  <= '0;
            crc_end_reg  <= '0;
            crc_feed_reg <= 1'b0;
        end else begin
            if (state_reg == ST_CLEAR) begin
                clr_reg <= clr_reg + RAM_AW'(1);
            end
            crc_feed_reg <= (state_reg == ST_CRC);
            if (accept && is_crc) begin
                crc_adr_reg <= (dbg.op == brp_pkg::DOP_CRC_FACT) ?
                               brp_pkg::PROT_BYTE_ADR : USER_FIRST;
                crc_end_reg <= (dbg.op == brp_pkg::DOP_CRC_FACT) ?
                               FACT_LAST : USER_LAST;
            end else if (state_reg == ST_CRC) begin
                crc_adr_reg <= crc_adr_reg + AW'(1);
            end
        end
    end

    // ****************************************************************
    // Answers to the station and to software
    // ****************************************************************
    wire fin = (state_reg == ST_DREAD) || (state_reg == ST_CRCEND) ||
               (accept && dbg.op == brp_pkg::DOP_WRITE);
    wire [7:0] status = {done_reg, open_reg, run_reg, xo_reg,
                         4'(state_reg)};

    // Station read data holds until the next read; register read data lasts
    // one cycle only; the byte itself is never returned here.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_reg       <= 1'b0;
            ref_reg       <= 1'b0;
            rdata_reg     <= 8'h00;
            reg_rdata_reg <= 8'h00;
        end else begin
            ack_reg <= fin;
            ref_reg <= refuse;
            if (state_reg == ST_DREAD) begin
                rdata_reg <= nvm_rdata;
            end
            if (reg_rd) begin
                reg_rdata_reg <=
                    (reg_addr == brp_pkg::REG_LIVE)   ? live_reg :
                    (reg_addr == brp_pkg::REG_STATUS) ? status : 8'h00;
            end else begin
                reg_rdata_reg <= 8'h00;
            end
        end
    end

    brp_crc32 u_crc (
        .clk   (clk),
        .reset (reset),
        .init  (accept & is_crc),
        .feed  (crc_feed_reg),
        .data  (nvm_rdata),
        .crc   (crc_val)
    );

    // NVM port: boot fetch, station reads, writes and CRC walk
    assign nvm.rd    = (state_reg == ST_FETCH) || (state_reg == ST_CRC) ||
                       (accept && dbg.op == brp_pkg::DOP_READ);
    assign nvm.we    = accept && dbg.op == brp_pkg::DOP_WRITE;
    assign nvm.addr  = (state_reg == ST_FETCH) ? brp_pkg::PROT_BYTE_ADR :
                       (state_reg == ST_CRC) ? crc_adr_reg : dbg.addr;
    assign nvm.wdata = wr_byte;

    // Output assignments
    assign load_go      = (state_reg == ST_LOAD);
    assign load_user    = ~retest_reg; // Retest loads factory image only
    assign early_xo_en  = xo_reg;
    assign user_run     = run_reg;
    assign boot_done    = done_reg;
    assign debug_open   = port_ok;
    assign eeprom_lock  = live_reg[brp_pkg::LP_EE_LOCK];
    assign nvm_lock     = lk_nvm;
    assign ram_clr_we   = (state_reg == ST_CLEAR);
    assign ram_clr_addr = clr_reg;
    assign dbg_ack      = ack_reg;
    assign dbg_refused  = ref_reg;
    assign dbg_rdata    = rdata_reg;
    assign dbg_crc      = crc_val;
    assign reg_rdata    = reg_rdata_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ee_lock_set: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_EELOCK && f_ee) |=> eeprom_lock)
        else $error("EEPROM lock not set on retest flag");

    a_nvm_lock_last: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_NVLOCK && f_nvm) |=> nvm_lock ##0
        (state_reg == ST_READY))
        else $error("NVM lock not set as last boot step");

    a_vendor_read: assert property (@(posedge clk) disable iff (reset)
        (take && port_ok && dbg.op == brp_pkg::DOP_READ && in_vend)
        |-> nvm.rd ##1 (state_reg == ST_DREAD) ##1 dbg_ack)
        else $error("Vendor region read not served");

    a_locked_refuse: assert property (@(posedge clk) disable iff (reset)
        (take && lk_nvm && dbg.op == brp_pkg::DOP_WRITE)
        |-> !nvm.we ##1 dbg_refused)
        else $error("Write passed NVM lock");

    a_prot_no_clear: assert property (@(posedge clk) disable iff (reset)
        (nvm.we && nvm.addr == brp_pkg::PROT_BYTE_ADR)
        |-> ((nvm.wdata & prot_reg) == prot_reg))
        else $error("Protection bit cleared");

    a_xo_first: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_CATCH && nvm_rdata[brp_pkg::PB_EARLY_XO])
        |=> early_xo_en && load_go)
        else $error("Oscillator not started before load");

    a_auto_run: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_LOAD && load_done && at_user && !retest_reg)
        |=> (user_run == prot_reg[brp_pkg::PB_AUTO_RUN]))
        else $error("Auto run decision wrong at user level");

    a_live_sticky: assert property (@(posedge clk) disable iff (reset)
        ((live_reg & $past(live_reg)) == $past(live_reg)))
        else $error("Live protection bit cleared");

    a_open_after: assert property (@(posedge clk) disable iff (reset)
        $rose(debug_open) && retest_reg |->
        (eeprom_lock == f_ee) && (nvm_lock == f_nvm))
        else $error("Port opened before retest actions");

endmodule // brp_loader

`default_nettype wire

// ==== bench/brp_nvm_model.sv ====
// NVM model on the loader's memory port: data one cycle after rd.
// Assumes a fixed pattern everywhere except the protection byte.
`timescale 1ns/1ns
`default_nettype none

module brp_nvm_model (
    // System
    input  wire logic              clk,
    // Memory port
    input  wire brp_pkg::brp_nvm_s nvm,
    input  wire logic [7:0]        prot_byte,
    output logic      [7:0]        rdata
);
    initial rdata = 8'h00;
    // Idle cycles toggle so stale data is never mistaken for an answer
    always @(posedge clk) begin
        if (nvm.rd)
            rdata <= (nvm.addr == 13'h0000) ? prot_byte
                   : nvm.addr[7:0] ^ 8'h5A;
        else
            rdata <= ~rdata;
    end
endmodule // brp_nvm_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the retest protection loader.
// Assumes the NVM model answers reads; the bench plays the station.
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk = 0, reset = 1, boot_start = 0, retest_seen = 0;
    logic load_done = 0, dbg_req = 0, reg_wr = 0, reg_rd = 0, ok;
    logic [2:0] fuse_level = 3'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, pb = 8'h00, d;
    logic [7:0] nvm_rdata, dbg_rdata, reg_rdata;
    logic load_go, load_user, early_xo_en, user_run, boot_done, debug_open;
    logic eeprom_lock, nvm_lock, ram_clr_we, dbg_ack, dbg_refused;
    logic [31:0] dbg_crc, r;
    brp_pkg::brp_nvm_s nvm;
    brp_pkg::brp_dbg_s dbg = '0;
    int fail_count = 0, total_checks = 0, clr_n = 0;
    int seed = 32'h82673bca;

    always #50 clk = ~clk;
    // Loader copy is reported done one cycle after it starts
    always @(posedge clk) load_done <= load_go;
    // Clear writes seen since reset
    always @(posedge clk) clr_n <= reset ? 0 : clr_n + int'(ram_clr_we);

    brp_loader #(.RAM_WORDS(16), .RAM_AW(4)) dut_u (
        .clk, .reset, .boot_start, .retest_seen, .fuse_level, .load_done,
        .load_go, .load_user, .early_xo_en, .user_run, .boot_done,
        .debug_open, .eeprom_lock, .nvm_lock, .ram_clr_we,
        .ram_clr_addr(), .nvm, .nvm_rdata, .dbg_req, .dbg, .dbg_ack,
        .dbg_refused, .dbg_rdata, .dbg_crc, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    brp_nvm_model nvm_u (.clk, .nvm, .prot_byte(pb), .rdata(nvm_rdata));

    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Register port: one-cycle strobes, read data in the next cycle only
    task automatic reg_io(input logic w, input logic [3:0] a,
                          input logic [7:0] wd);
        @(posedge clk) begin
            reg_addr <= a;
            reg_wdata <= wd;
            reg_wr <= w;
            reg_rd <= !w;
        end
        @(posedge clk) begin
            reg_wr <= 0;
            reg_rd <= 0;
        end
        #1 d = reg_rdata;
    endtask

    // Station request held for one cycle, then wait for ack or refusal
    task automatic dbg_op(input brp_pkg::brp_dop_e op, input logic [12:0] a);
        int n;
        @(posedge clk) begin
            dbg_req <= 1;
            dbg <= '{op, a, 8'hFF};
        end
        @(posedge clk) dbg_req <= 0;
        #1 n = 0;
        while (dbg_ack !== 1'b1 && dbg_refused !== 1'b1 && n < 9000) begin
            @(posedge clk) #1 n++;
        end
        ok = dbg_ack;
    endtask

    function automatic logic [31:0] crc_of(input int lo, hi);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int a = lo; a < hi; a++) begin
            c ^= {24'h0, (a == 0) ? pb : a[7:0] ^ 8'h5A};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction

    // Full boot from reset, then outputs and live register against rules
    task automatic boot(input logic [2:0] lv, input logic rt,
                        input logic [7:0] b);
        int n;
        logic lk, rn;
        lk = (lv == brp_pkg::LVL_RUN) && rt;
        rn = (lv == brp_pkg::LVL_RUN);
        @(posedge clk) begin
            reset <= 1;
            fuse_level <= lv;
            retest_seen <= rt;
            pb <= b;
        end
        repeat (5) @(posedge clk);
        reset <= 0;
        @(posedge clk) boot_start <= 1;
        @(posedge clk) boot_start <= 0;
        #1 n = 0;
        while (boot_done !== 1'b1 && n < 200) begin
            @(posedge clk) #1 n++;
        end
        chk({eeprom_lock, nvm_lock}, {lk & b[6], lk & b[7]});
        chk({early_xo_en, user_run, debug_open}, {b[4],
            (lv == brp_pkg::LVL_USER && b[1]) || (rn && !rt),
            !(rn && !rt)});
        chk(clr_n, (lk && b[5]) ? 16 : 0);
        chk(load_user, !lk);
        reg_io(1, brp_pkg::REG_LIVE, 8'h08);
        reg_io(0, brp_pkg::REG_LIVE, 8'h00);
        chk(d, {lk & b[7], 2'b01, lk & b[6], 1'b1, lv});
        reg_io(0, brp_pkg::REG_STATUS, 8'h00);
        chk(d, {1'b1, !(rn && !rt), (lv == brp_pkg::LVL_USER && b[1]) || (rn && !rt), b[4], 4'h7});
        reg_io(0, 4'hF, 8'h00);
        chk(d, 8'h00);
    endtask

    initial begin
        #(100 * 40000);
        fail_count++;
        conclude();
    end

    initial begin
        r = $random(seed);
        boot(3'h7, 1, 8'hF0 | (r[7:0] & 8'h0F));
        dbg_op(brp_pkg::DOP_READ, 13'h1FFF);
        chk({ok, dbg_rdata}, {1'b1, 8'hA5});
        dbg_op(brp_pkg::DOP_READ, 13'h1FBF);
        chk(ok, 0);
        dbg_op(brp_pkg::DOP_WRITE, 13'h0000);
        chk(ok, 0);
        dbg_op(brp_pkg::DOP_CRC_FACT, 13'h0000);
        chk(dbg_crc, crc_of(0, 1024));
        dbg_op(brp_pkg::DOP_CRC_USER, 13'h0000);
        chk(dbg_crc, crc_of(1024, 8128));
        boot(3'h7, 1, 8'h2D);
        for (int i = 0; i < 9; i++) begin
            r = $random(seed);
            boot((i % 3 == 0) ? 3'h1 : (i % 3 == 1) ? 3'h3 : 3'h7,
                 r[8], r[7:0]);
        end
        conclude();
    end
endmodule // tb
`default_nettype wire
